// ### logic/pvd_pkg.sv
// Purpose: Shared constants for the voltage-down, current-up contract sequencer pair.
// Assumes: Both ends run on one 40 MHz clock and meet at message level.
// Notes:   Timer figures are plain defaults; each end takes them as parameters.
package pvd_pkg;
   // Message codes carried on the link.
   localparam logic [1:0] MSG_NONE        = 2'h0;
   localparam logic [1:0] MSG_ACCEPT      = 2'h1;
   localparam logic [1:0] MSG_PS_RDY      = 2'h2;
   // Clock rate in kHz.
   localparam int unsigned CLK_KHZ        = 40000;
   // Times in microseconds.
   localparam int unsigned T_SRC_TRANS_US = 25;
   localparam int unsigned T_SRC_READY_US = 100;
   localparam int unsigned T_CRC_WAIT_US  = 1;
   localparam int unsigned T_PS_TRANS_US  = 500;
   localparam int unsigned T_SNK_STDBY_US = 20;
   // Least times round up, longest times round down.
   localparam int unsigned SRC_TRANS_CYC  = (T_SRC_TRANS_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned SRC_READY_CYC  = (T_SRC_READY_US * CLK_KHZ) / 1000;
   localparam int unsigned CRC_WAIT_CYC   = (T_CRC_WAIT_US * CLK_KHZ) / 1000;
   localparam int unsigned PS_TRANS_CYC   = (T_PS_TRANS_US * CLK_KHZ) / 1000;
   localparam int unsigned SNK_STDBY_CYC  = (T_SNK_STDBY_US * CLK_KHZ) / 1000;
   // Failure codes reported by the source end.
   localparam logic [1:0] FAIL_NONE       = 2'h0;
   localparam logic [1:0] FAIL_CRC_ACC    = 2'h1;
   localparam logic [1:0] FAIL_READY      = 2'h2;
   localparam logic [1:0] FAIL_CRC_RDY    = 2'h3;
endpackage : pvd_pkg

// ### logic/pvd_link_if.sv
// Purpose: Message-level link between the source end and the sink end.
// Assumes: Both ends share mclk_in; a message or GoodCRC lasts one cycle.
// Notes:   The sink answers each message with GoodCRC on the next cycle.
`timescale 1ns/10ps
`default_nettype none
interface pvd_link_if;
   logic       msg_vld;
   logic [1:0] msg_type;
   logic       crc_vld;

   modport src (
      output msg_vld,
      output msg_type,
      input  crc_vld
   );

   modport snk (
      input  msg_vld,
      input  msg_type,
      output crc_vld
   );
endinterface : pvd_link_if
`default_nettype wire

// ### logic/pvd_source.sv
// Purpose: Source end of a contract change that lowers voltage and raises current.
// Assumes: The policy has already accepted the sink's Request; supply ready is a pin.
// Notes:   One transition at a time; a failure returns the end to idle.
//
// What this block and the sink do
// R1: Source sends Accept after accepting the Request.
// R2: Sink starts its transition timer on Accept.
// R3: Sink answers Accept with GoodCRC, then evaluates.
// R4: Source waits tSrcTransition after GoodCRC for Accept.
// R5: Sink reaches standby within tSnkStdby, before transition.
// R6: After the wait, source orders the new voltage.
// R7: Supply reports ready within tSrcReady, forwarded here.
// R8: On supply ready, source sends PS_RDY.
// R9: GoodCRC for PS_RDY completes the exchange.
// R10: Sink acks PS_RDY, evaluates, permits new power.
// R11: Sink draws new power only after evaluation.
// R12: Sink flags failure if its timer expires.
`timescale 1ns/10ps
`default_nettype none
module pvd_source #(
   parameter int unsigned TRANS_CYC = pvd_pkg::SRC_TRANS_CYC,
   parameter int unsigned READY_CYC = pvd_pkg::SRC_READY_CYC,
   parameter int unsigned CRC_CYC   = pvd_pkg::CRC_WAIT_CYC
) (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   // Link toward the sink
   pvd_link_if.src         link,
   // Policy side
   input  wire logic       request_ok_in,
   output logic            busy_out,
   output logic            done_out,
   output logic            fail_out,
   output logic [1:0]      fail_code_out,
   // Power supply side
   input  wire logic       supply_ready_in,
   output logic            supply_change_out
);

   localparam int unsigned MAX_A = (TRANS_CYC > READY_CYC) ? TRANS_CYC : READY_CYC;
   localparam int unsigned MAX_C = (MAX_A > CRC_CYC) ? MAX_A : CRC_CYC;
   localparam int unsigned CW    = $clog2(MAX_C + 1);

   generate
      if (TRANS_CYC < 1 || READY_CYC < 1 || CRC_CYC < 1) begin : g_bad_count
         $error("pvd_source: every timer count must be at least one cycle");
      end
   endgenerate

   typedef enum logic [6:0] {
      S_IDLE    = 7'h01,
      S_ACC_TX  = 7'h02,
      S_ACC_CRC = 7'h04,
      S_TRANS   = 7'h08,
      S_READY   = 7'h10,
      S_RDY_TX  = 7'h20,
      S_RDY_CRC = 7'h40
   } pvd_src_state_t;

   pvd_src_state_t state;
   pvd_src_state_t next_state;
   logic [CW-1:0]  cnt;
   logic [2:0]     rdy_sync;
   logic           rdy_level;
   logic           cnt_trans_end;
   logic           cnt_ready_end;
   logic           cnt_crc_end;

   assign cnt_trans_end = (cnt == CW'(TRANS_CYC - 1));
   assign cnt_ready_end = (cnt == CW'(READY_CYC - 1));
   assign cnt_crc_end   = (cnt == CW'(CRC_CYC - 1));

   // The ready pin is asynchronous to mclk_in; the first stage feeds only the second.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdy_sync <= 3'h0;
      end else begin
         rdy_sync <= {rdy_sync[1:0], supply_ready_in};
      end
   end

   // A level change counts only once the second and third stages agree.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdy_level <= 1'b0;
      end else if (rdy_sync[1] == rdy_sync[2]) begin
         rdy_level <= rdy_sync[2];
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (request_ok_in) begin
               next_state = S_ACC_TX; // R1
            end
         end
         S_ACC_TX: begin
            next_state = S_ACC_CRC;
         end
         S_ACC_CRC: begin
            if (link.crc_vld) begin
               next_state = S_TRANS; // R4
            end else if (cnt_crc_end) begin
               next_state = S_IDLE;
            end
         end
         S_TRANS: begin
            if (cnt_trans_end) begin
               next_state = S_READY; // R6
            end
         end
         S_READY: begin
            if (rdy_level) begin
               next_state = S_RDY_TX; // R7
            end else if (cnt_ready_end) begin
               next_state = S_IDLE; // R7
            end
         end
         S_RDY_TX: begin
            next_state = S_RDY_CRC;
         end
         S_RDY_CRC: begin
            if (link.crc_vld || cnt_crc_end) begin
               next_state = S_IDLE; // R9
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // One shared counter serves every wait; it restarts whenever the state changes.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt <= '0;
      end else if (state != next_state) begin
         cnt <= '0;
      end else if (cnt != {CW{1'b1}}) begin
         cnt <= cnt + CW'(1);
      end
   end

   // Messages leave in the cycle after the state that sends them is entered.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         link.msg_vld  <= 1'b0;
         link.msg_type <= pvd_pkg::MSG_NONE;
      end else if (state == S_ACC_TX) begin
         link.msg_vld  <= 1'b1; // R1
         link.msg_type <= pvd_pkg::MSG_ACCEPT; // R1
      end else if (state == S_RDY_TX) begin
         link.msg_vld  <= 1'b1; // R8
         link.msg_type <= pvd_pkg::MSG_PS_RDY; // R8
      end else begin
         link.msg_vld  <= 1'b0;
         link.msg_type <= pvd_pkg::MSG_NONE;
      end
   end

   // The supply is ordered only once the full transition wait has run out.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         supply_change_out <= 1'b0;
      end else begin
         supply_change_out <= (state == S_TRANS) && cnt_trans_end; // R6
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= (state == S_RDY_CRC) && link.crc_vld; // R9
      end
   end

   // A GoodCRC outside a wait state is ignored; a missing one ends the change.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fail_out <= 1'b0;
      end else begin
         fail_out <= ((state == S_ACC_CRC) && !link.crc_vld && cnt_crc_end)
                  || ((state == S_READY) && !rdy_level && cnt_ready_end)
                  || ((state == S_RDY_CRC) && !link.crc_vld && cnt_crc_end);
      end
   end

   // The code of the last failure stays until the next transition starts.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fail_code_out <= pvd_pkg::FAIL_NONE;
      end else if (state == S_IDLE && request_ok_in) begin
         fail_code_out <= pvd_pkg::FAIL_NONE;
      end else if (state == S_ACC_CRC && !link.crc_vld && cnt_crc_end) begin
         fail_code_out <= pvd_pkg::FAIL_CRC_ACC;
      end else if (state == S_READY && !rdy_level && cnt_ready_end) begin
         fail_code_out <= pvd_pkg::FAIL_READY;
      end else if (state == S_RDY_CRC && !link.crc_vld && cnt_crc_end) begin
         fail_code_out <= pvd_pkg::FAIL_CRC_RDY;
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (next_state != S_IDLE);
      end
   end

endmodule : pvd_source
`default_nettype wire

// ### logic/pvd_sink.sv
// Purpose: Sink end of a contract change that lowers voltage and raises current.
// Assumes: The standby-reached signal arrives from the supply as a pin.
// Notes:   Every message is acknowledged with GoodCRC on the next cycle.
`timescale 1ns/10ps
`default_nettype none
module pvd_sink #(
   parameter int unsigned PS_CYC    = pvd_pkg::PS_TRANS_CYC,
   parameter int unsigned STDBY_CYC = pvd_pkg::SNK_STDBY_CYC
) (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   // Link toward the source
   pvd_link_if.snk         link,
   // Power manager side
   input  wire logic       standby_reached_in,
   output logic            standby_cmd_out,
   output logic            standby_late_out,
   output logic            new_power_ok_out,
   output logic            fail_out,
   output logic            busy_out
);

   localparam int unsigned PW = $clog2(PS_CYC + 1);
   localparam int unsigned SW = $clog2(STDBY_CYC + 1);

   generate
      if (PS_CYC < 1 || STDBY_CYC < 1) begin : g_bad_count
         $error("pvd_sink: every timer count must be at least one cycle");
      end
   endgenerate

   typedef enum logic [3:0] {
      K_IDLE     = 4'h1,
      K_ACC_ACK  = 4'h2,
      K_WAIT_RDY = 4'h4,
      K_RDY_ACK  = 4'h8
   } pvd_snk_state_t;

   pvd_snk_state_t state;
   logic [PW-1:0]  ps_cnt;
   logic [SW-1:0]  sb_cnt;
   logic [2:0]     sb_sync;
   logic           sb_level;
   logic           got_accept;
   logic           got_ps_rdy;
   logic           ps_expired;

   assign got_accept = link.msg_vld && (link.msg_type == pvd_pkg::MSG_ACCEPT);
   assign got_ps_rdy = link.msg_vld && (link.msg_type == pvd_pkg::MSG_PS_RDY);
   assign ps_expired = (state == K_WAIT_RDY) && (ps_cnt == PW'(PS_CYC - 1)) && !got_ps_rdy;

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         link.crc_vld <= 1'b0;
      end else begin
         link.crc_vld <= link.msg_vld; // R3 R10
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sb_sync  <= 3'h0;
      end else begin
         sb_sync  <= {sb_sync[1:0], standby_reached_in};
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sb_level <= 1'b0;
      end else if (sb_sync[1] == sb_sync[2]) begin
         sb_level <= sb_sync[2];
      end
   end

   // A fresh Accept restarts the sequence from any state but K_ACC_ACK.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= K_IDLE;
      end else begin
         case (state)
            K_IDLE:     state <= got_accept ? K_ACC_ACK : K_IDLE;
            K_ACC_ACK:  state <= K_WAIT_RDY; // R3
            K_WAIT_RDY: begin
               if (got_accept) begin
                  state <= K_ACC_ACK;
               end else if (got_ps_rdy) begin
                  state <= K_RDY_ACK;
               end else if (ps_expired) begin
                  state <= K_IDLE; // R12
               end
            end
            K_RDY_ACK:  state <= got_accept ? K_ACC_ACK : K_IDLE;
            default:    state <= K_IDLE;
         endcase
      end
   end

   // The transition timer starts with the Accept itself.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ps_cnt <= '0;
      end else if (got_accept) begin
         ps_cnt <= '0; // R2
      end else if (state != K_IDLE && ps_cnt != {PW{1'b1}}) begin
         ps_cnt <= ps_cnt + PW'(1); // R2
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fail_out <= 1'b0;
      end else begin
         fail_out <= ps_expired; // R12
      end
   end

   // Standby is commanded after the Accept has been acknowledged and evaluated.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         standby_cmd_out <= 1'b0;
      end else if (state == K_ACC_ACK) begin
         standby_cmd_out <= 1'b1; // R5
      end else if (state == K_RDY_ACK || ps_expired) begin
         standby_cmd_out <= 1'b0;
      end
   end

   // The late flag fires once if standby is not reached within its window.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sb_cnt           <= '0;
         standby_late_out <= 1'b0;
      end else begin
         standby_late_out <= 1'b0;
         if (!standby_cmd_out || sb_level) begin
            sb_cnt <= '0;
         end else if (sb_cnt != SW'(STDBY_CYC)) begin
            sb_cnt <= sb_cnt + SW'(1);
            standby_late_out <= (sb_cnt == SW'(STDBY_CYC - 1)); // R5
         end
      end
   end

   // New power is permitted only once PS_RDY is acknowledged and evaluated.
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         new_power_ok_out <= 1'b0;
      end else if (got_accept) begin
         new_power_ok_out <= 1'b0; // R11
      end else if (state == K_RDY_ACK) begin
         new_power_ok_out <= 1'b1; // R10 R11
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= (state == K_ACC_ACK) || (state == K_WAIT_RDY) || got_accept;
      end
   end

endmodule : pvd_sink
`default_nettype wire

// ### dv/pvd_link_checker.sv
// Purpose: Concurrent checks on the link and on the key outputs of both ends.
// Assumes: One clock domain; TRANS_CYC matches the source instance.
// Notes:   The sink timeout is judged by the testbench.
`timescale 1ns/10ps
`default_nettype none
module pvd_link_checker #(
   parameter int unsigned TRANS_CYC = 8
) (
   // Clock and reset
   input wire logic       mclk_in,
   input wire logic       sys_rst_in,
   // Link
   input wire logic       msg_vld,
   input wire logic [1:0] msg_type,
   input wire logic       crc_vld,
   // End outputs and supply
   input wire logic       supply_change_out,
   input wire logic       supply_ready_in,
   input wire logic       done_out,
   input wire logic       standby_cmd_out,
   input wire logic       new_power_ok_out
);
   localparam int TLO = TRANS_CYC;
   localparam int THI = TRANS_CYC + 4;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_crc_follows_msg: assert property (msg_vld |=> crc_vld)
      else $error("GoodCRC missing after a message");
   a_crc_needs_msg: assert property (crc_vld |-> $past(msg_vld))
      else $error("GoodCRC without a message");
   a_msg_single_pulse: assert property (msg_vld |=> !msg_vld)
      else $error("Message strobe longer than one cycle");
   a_msg_type_legal: assert property (msg_vld |-> msg_type != pvd_pkg::MSG_NONE)
      else $error("Message strobe with no message type");
   a_change_after_wait: assert property ((crc_vld && $past(msg_type) == pvd_pkg::MSG_ACCEPT)
      |-> ##[TLO:THI] supply_change_out)
      else $error("Supply change not ordered after the transition wait");
   a_rdy_after_supply: assert property ((msg_vld && msg_type == pvd_pkg::MSG_PS_RDY)
      |-> $past(supply_ready_in, 2))
      else $error("Supply ready message before the supply was ready");
   a_done_after_crc: assert property ((crc_vld && $past(msg_type) == pvd_pkg::MSG_PS_RDY)
      |=> done_out)
      else $error("Done missing after GoodCRC for supply ready");
   a_standby_on_accept: assert property ((msg_vld && msg_type == pvd_pkg::MSG_ACCEPT)
      |-> ##2 standby_cmd_out)
      else $error("Standby command missing after accept");
   a_power_after_rdy: assert property ((msg_vld && msg_type == pvd_pkg::MSG_PS_RDY)
      |-> ##2 new_power_ok_out)
      else $error("New power not permitted after supply ready");
   a_no_early_power: assert property ($rose(new_power_ok_out) |-> $past(crc_vld))
      else $error("New power permitted before supply ready was acknowledged");
endmodule : pvd_link_checker
`default_nettype wire

// ### dv/test_pd_voltage_down_current_up_seq.sv
// Purpose: Runs both ends against each other, and one source against a stalling far side.
// Assumes: Shortened timers; the far side withholds GoodCRC per message type.
// Notes:   Pulse outputs are counted by a monitor and compared after each test.
`timescale 1ns/10ps
`default_nettype none
module test_pd_voltage_down_current_up_seq;
   localparam int unsigned TRANS = 8;
   localparam int unsigned READY = 16;
   localparam int unsigned CRC   = 4;
   localparam int unsigned PS    = 64;
   localparam int unsigned STDBY = 10;
   localparam logic [1:0]  MASKS [3] = '{2'h3, 2'h1, 2'h0};
   localparam logic [1:0]  CODES [3] = '{pvd_pkg::FAIL_NONE, pvd_pkg::FAIL_CRC_RDY,
                                         pvd_pkg::FAIL_CRC_ACC};
   logic       mclk_in, sys_rst_in, req, req2, rdy_en, stdby_en, sup_rdy, sup_rdy2, stdby_in;
   logic       cnt_clr;
   logic       s_busy, s_done, s_fail, s_chg, k_cmd, k_late, k_pow, k_fail, k_busy;
   logic       s2_busy, s2_done, s2_fail, s2_chg;
   logic [1:0] s_code, s2_code, ack_mask;
   int         cnt [8];
   int         errors;
   int         checked;
   pvd_link_if link ();
   pvd_link_if link2 ();
   pvd_source #(.TRANS_CYC(TRANS), .READY_CYC(READY), .CRC_CYC(CRC)) u_pvd_source (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link), .request_ok_in(req),
      .busy_out(s_busy), .done_out(s_done), .fail_out(s_fail), .fail_code_out(s_code),
      .supply_ready_in(sup_rdy), .supply_change_out(s_chg));
   pvd_sink #(.PS_CYC(PS), .STDBY_CYC(STDBY)) u_pvd_sink (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link),
      .standby_reached_in(stdby_in), .standby_cmd_out(k_cmd), .standby_late_out(k_late),
      .new_power_ok_out(k_pow), .fail_out(k_fail), .busy_out(k_busy));
   pvd_source #(.TRANS_CYC(TRANS), .READY_CYC(READY), .CRC_CYC(CRC)) u_pvd_source_2 (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link2), .request_ok_in(req2),
      .busy_out(s2_busy), .done_out(s2_done), .fail_out(s2_fail), .fail_code_out(s2_code),
      .supply_ready_in(sup_rdy2), .supply_change_out(s2_chg));
   pvd_link_checker #(.TRANS_CYC(TRANS)) u_pvd_link_checker (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .msg_vld(link.msg_vld),
      .msg_type(link.msg_type), .crc_vld(link.crc_vld), .supply_change_out(s_chg),
      .supply_ready_in(sup_rdy), .done_out(s_done), .standby_cmd_out(k_cmd),
      .new_power_ok_out(k_pow));
   initial begin
      mclk_in = 1'h0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // Supplies report ready only after being ordered, so an early ready cannot mask a fault.
   always @(posedge mclk_in) begin
      stdby_in <= stdby_en & k_cmd;
      sup_rdy <= rdy_en & (sup_rdy | s_chg);
      sup_rdy2 <= ack_mask[0] & (sup_rdy2 | s2_chg);
      link2.crc_vld <= link2.msg_vld & ack_mask[link2.msg_type == pvd_pkg::MSG_PS_RDY];
      if (cnt_clr) begin
         cnt <= '{default: 0};
      end else begin
         cnt[0] <= cnt[0] + s_done;
         cnt[1] <= cnt[1] + s_fail;
         cnt[2] <= cnt[2] + k_fail;
         cnt[3] <= cnt[3] + k_late;
         cnt[4] <= cnt[4] + (link.msg_vld && link.msg_type == pvd_pkg::MSG_ACCEPT);
         cnt[5] <= cnt[5] + (link.msg_vld && link.msg_type == pvd_pkg::MSG_PS_RDY);
         cnt[6] <= cnt[6] + s2_fail;
         cnt[7] <= cnt[7] + s2_done;
      end
   end
   task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic transfer(input logic use2, input logic rdy, input logic stdby,
                           input logic [1:0] mask);
      int n;
      // Dropping both supply enables for a cycle clears a stale ready from the last test.
      @(posedge mclk_in);
      cnt_clr  <= 1'h1;
      rdy_en   <= 1'h0;
      ack_mask <= 2'h0;
      @(posedge mclk_in);
      cnt_clr  <= 1'h0;
      rdy_en <= rdy;
      stdby_en <= stdby;
      ack_mask <= mask;
      if (use2) req2 <= 1'h1;
      else req <= 1'h1;
      @(posedge mclk_in);
      req <= 1'h0;
      req2 <= 1'h0;
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
      end while ((s_busy | k_busy | s2_busy) !== 1'h0 && n < 400);
      if (n >= 400) begin
         errors++;
         $display("BAD %0t transfer never finished", $time);
      end
      // Done and fail pulses leave no later than the last busy edge and are counted one edge later.
      repeat (2) @(negedge mclk_in);
   endtask : transfer
   task automatic summarize();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (6000) @(posedge mclk_in);
      errors++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      {sys_rst_in, req, req2, rdy_en, stdby_en} = 5'h10;
      ack_mask = 2'h0;
      cnt_clr = 1'h1;
      errors = 0;
      checked = 0;
      repeat (20) @(posedge mclk_in);
      sys_rst_in <= 1'h0;
      transfer(1'h0, 1'h1, 1'h1, 2'h0);
      chk(cnt[4][1:0], 2'h1, "accepts sent");
      chk(cnt[5][1:0], 2'h1, "ready messages sent");
      chk(cnt[0][1:0], 2'h1, "source done");
      chk(s_code, pvd_pkg::FAIL_NONE, "source fail code");
      chk({1'h0, k_pow}, 2'h1, "new power permitted");
      chk(cnt[3][1:0], 2'h0, "standby late");
      chk(cnt[2][1:0], 2'h0, "sink timeout");
      $display("test normal transition done");
      transfer(1'h0, 1'h1, 1'h0, 2'h0);
      chk(cnt[3][1:0], 2'h1, "standby late");
      chk(cnt[0][1:0], 2'h1, "source done");
      $display("test standby never reached done");
      transfer(1'h0, 1'h0, 1'h1, 2'h0);
      chk(s_code, pvd_pkg::FAIL_READY, "source fail code");
      chk(cnt[1][1:0], 2'h1, "source fail pulses");
      chk(cnt[5][1:0], 2'h0, "ready messages sent");
      chk(cnt[2][1:0], 2'h1, "sink timeout");
      chk({1'h0, k_pow}, 2'h0, "new power permitted");
      $display("test supply never ready done");
      for (int i = 0; i < 3; i++) begin
         transfer(1'h1, 1'h0, 1'h0, MASKS[i]);
         chk(s2_code, CODES[i], "stalled far side fail code");
         chk(cnt[7][1:0], {1'h0, i == 0}, "stalled far side done");
         chk(cnt[6][1:0], {1'h0, i != 0}, "stalled far side fail pulses");
         $display("test stalled far side %0d done", i);
      end
      summarize();
   end
endmodule : test_pd_voltage_down_current_up_seq
`default_nettype wire
